//--- rtl/rdc_pkg.sv
// rdc_pkg: shared constants and types for the read-calibration pattern link
package rdc_pkg;
   localparam int DQ_W = 16;
   localparam int DMI_W = 2;
   localparam int BURST_LEN = 16;
   localparam int CNT_W = 4;
   localparam logic [7:0] FIRST_PATTERN_RST = 8'h5a;
   localparam logic [7:0] SECOND_PATTERN_RST = 8'h3c;
   localparam logic [7:0] LOW_MASK_RST = 8'h55;
   localparam logic [7:0] HIGH_MASK_RST = 8'h55;
   localparam logic [7:0] CFG_RST = 8'h00;
   // mode-register write selectors carried on the link
   localparam logic [2:0] SEL_FIRST = 3'h0;
   localparam logic [2:0] SEL_SECOND = 3'h1;
   localparam logic [2:0] SEL_LOW_MASK = 3'h2;
   localparam logic [2:0] SEL_HIGH_MASK = 3'h3;
   localparam logic [2:0] SEL_CFG = 3'h4;
   // config byte bit positions
   localparam int DM_DIS_BIT = 5;
   localparam int RD_INV_BIT = 6;
   localparam int WR_INV_BIT = 7;
   // read latency in cycles, reset value and width
   localparam logic [5:0] RL_RST = 6'h06;
   localparam int RL_W = 6;
   // link commands
   typedef enum logic [1:0] {
      RDC_CMD_NONE = 2'b00,
      RDC_CMD_MRW = 2'b01,
      RDC_CMD_CAL = 2'b10,
      RDC_CMD_CAS2 = 2'b11
   } rdc_cmd_t;
   // controller register offsets (word index on the software port)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_MRW = 4'h2;
   localparam logic [3:0] REG_RL = 4'h3;
   localparam logic [3:0] REG_CAP_LO = 4'h4;
   localparam logic [3:0] REG_CAP_HI = 4'h5;
endpackage

//--- rtl/rdc_link_if.sv
// rdc_link_if: command and pin-level link between controller and memory
`timescale 1ns/1ps
interface rdc_link_if;
   rdc_pkg::rdc_cmd_t cmd;
   logic [2:0] mrw_sel;
   logic [7:0] mrw_data;
   logic [5:0] cas2_op;
   logic [15:0] dq;
   logic [15:0] dq_oe;
   logic [1:0] dmi;
   logic [1:0] dmi_oe;
   modport mem (input cmd, input mrw_sel, input mrw_data, input cas2_op,
                output dq, output dq_oe, output dmi, output dmi_oe);
   modport ctl (output cmd, output mrw_sel, output mrw_data, output cas2_op,
                input dq, input dq_oe, input dmi, input dmi_oe);
endinterface

//--- rtl/rdc_mem.sv
// rdc_mem: memory-side read calibration pattern generator
//
// How it works
// R1: send first then second pattern, all lanes
// R2: one 16-bit burst after read latency
// R3: mask bit one complements that dq pin
// R4: low mask bits map to dq0..dq7
// R5: high mask bits map to dq8..dq15
// R6: dmi pins are never inverted
// R7: no bus-inversion coding during calibration
// R8: each byte goes out lsb first
// R9: reset values 5a, 3c, 55, 55
// R10: controller may program registers beforehand
// R11: cas-2 follows calibration command immediately
// R12: cas-2 operands driven low
// R13: back-to-back requests give seamless bursts
// R14: controller spaces array reads from calibration
// R15: accepted regardless of bank or refresh state
// R16: dmi floats only when mask and inversion off
// R17: controller waits after power-down exit
// R18: read-style timing, burst length sixteen
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module rdc_mem (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] read_latency_i,
   rdc_link_if.mem link,
   output logic busy_o
);
   localparam int PIPE = 64;
   logic [7:0] first_pattern_byte_r, first_pattern_byte_nxt;
   logic [7:0] second_pattern_byte_r, second_pattern_byte_nxt;
   logic [7:0] low_lane_invert_mask_r, low_lane_invert_mask_nxt;
   logic [7:0] high_lane_invert_mask_r, high_lane_invert_mask_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic armed_r, armed_nxt;
   logic [PIPE-1:0] start_r, start_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic active_r, active_nxt;
   logic [15:0] dq_r, dq_nxt;
   logic [15:0] dq_oe_r, dq_oe_nxt;
   logic [1:0] dmi_r, dmi_nxt;
   logic [1:0] dmi_oe_r, dmi_oe_nxt;
   logic launch;
   logic [15:0] pat;
   logic pbit;
   logic dmi_float;
   logic [15:0] inv;
   logic dmi_drive;

   // mode registers and command decode
   always_comb begin
      first_pattern_byte_nxt = first_pattern_byte_r;
      second_pattern_byte_nxt = second_pattern_byte_r;
      low_lane_invert_mask_nxt = low_lane_invert_mask_r;
      high_lane_invert_mask_nxt = high_lane_invert_mask_r;
      cfg_nxt = cfg_r;
      if (link.cmd == rdc_pkg::RDC_CMD_MRW) begin // R10
         case (link.mrw_sel)
            rdc_pkg::SEL_FIRST: first_pattern_byte_nxt = link.mrw_data;
            rdc_pkg::SEL_SECOND: second_pattern_byte_nxt = link.mrw_data;
            rdc_pkg::SEL_LOW_MASK: low_lane_invert_mask_nxt = link.mrw_data;
            rdc_pkg::SEL_HIGH_MASK: high_lane_invert_mask_nxt = link.mrw_data;
            rdc_pkg::SEL_CFG: cfg_nxt = link.mrw_data;
            default: cfg_nxt = cfg_r;
         endcase
      end
      // calibration only counts when cas-2 comes in the very next cycle
      armed_nxt = (link.cmd == rdc_pkg::RDC_CMD_CAL); // R11
      // no bank, refresh or self-refresh state gates acceptance
      launch = armed_r && (link.cmd == rdc_pkg::RDC_CMD_CAS2); // R15
      // latency pipe, tap chosen by read latency from cas-2
      start_nxt = {start_r[PIPE-2:0], launch}; // R2 R18
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         first_pattern_byte_r <= rdc_pkg::FIRST_PATTERN_RST; // R9
         second_pattern_byte_r <= rdc_pkg::SECOND_PATTERN_RST; // R9
         low_lane_invert_mask_r <= rdc_pkg::LOW_MASK_RST; // R9
         high_lane_invert_mask_r <= rdc_pkg::HIGH_MASK_RST; // R9
         cfg_r <= rdc_pkg::CFG_RST;
         armed_r <= 1'b0;
         start_r <= '0;
      end else begin
         first_pattern_byte_r <= first_pattern_byte_nxt;
         second_pattern_byte_r <= second_pattern_byte_nxt;
         low_lane_invert_mask_r <= low_lane_invert_mask_nxt;
         high_lane_invert_mask_r <= high_lane_invert_mask_nxt;
         cfg_r <= cfg_nxt;
         armed_r <= armed_nxt;
         start_r <= start_nxt;
      end
   end

   // burst serializer
   always_comb begin
      pat = {second_pattern_byte_r, first_pattern_byte_r}; // R1
      inv = {high_lane_invert_mask_r, low_lane_invert_mask_r}; // R4 R5
      dmi_float = cfg_r[rdc_pkg::DM_DIS_BIT] && !cfg_r[rdc_pkg::WR_INV_BIT]
                  && !cfg_r[rdc_pkg::RD_INV_BIT]; // R16
      bit_nxt = bit_r;
      active_nxt = active_r;
      // a new start on the last beat chains straight on
      if (read_latency_i != 6'h00 && start_r[read_latency_i - 6'h01]) begin // R13
         active_nxt = 1'b1;
         bit_nxt = 4'h0;
      end else if (active_r) begin
         bit_nxt = bit_r + 4'h1;
         if (bit_r == 4'hf) begin
            active_nxt = 1'b0;
         end
      end
      pbit = pat[bit_nxt]; // R8
      dmi_drive = active_nxt && !dmi_float; // R16
   end

   // one lane per pin; a pattern bit fans out to all of them
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq0 (.bit_i(pbit), .invert_i(inv[0]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[0]), .oe_o(dq_oe_nxt[0]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq1 (.bit_i(pbit), .invert_i(inv[1]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[1]), .oe_o(dq_oe_nxt[1]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq2 (.bit_i(pbit), .invert_i(inv[2]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[2]), .oe_o(dq_oe_nxt[2]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq3 (.bit_i(pbit), .invert_i(inv[3]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[3]), .oe_o(dq_oe_nxt[3]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq4 (.bit_i(pbit), .invert_i(inv[4]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[4]), .oe_o(dq_oe_nxt[4]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq5 (.bit_i(pbit), .invert_i(inv[5]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[5]), .oe_o(dq_oe_nxt[5]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq6 (.bit_i(pbit), .invert_i(inv[6]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[6]), .oe_o(dq_oe_nxt[6]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq7 (.bit_i(pbit), .invert_i(inv[7]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[7]), .oe_o(dq_oe_nxt[7]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq8 (.bit_i(pbit), .invert_i(inv[8]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[8]), .oe_o(dq_oe_nxt[8]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq9 (.bit_i(pbit), .invert_i(inv[9]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[9]), .oe_o(dq_oe_nxt[9]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq10 (.bit_i(pbit), .invert_i(inv[10]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[10]), .oe_o(dq_oe_nxt[10]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq11 (.bit_i(pbit), .invert_i(inv[11]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[11]), .oe_o(dq_oe_nxt[11]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq12 (.bit_i(pbit), .invert_i(inv[12]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[12]), .oe_o(dq_oe_nxt[12]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq13 (.bit_i(pbit), .invert_i(inv[13]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[13]), .oe_o(dq_oe_nxt[13]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq14 (.bit_i(pbit), .invert_i(inv[14]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[14]), .oe_o(dq_oe_nxt[14]));
   rdc_lane #(.INVERTIBLE(1'b1)) u_rdc_lane_dq15 (.bit_i(pbit), .invert_i(inv[15]),
      .drive_i(active_nxt),
      .dat_o(dq_nxt[15]), .oe_o(dq_oe_nxt[15]));
   // dmi lanes have no mask bit and are built without the inverter
   rdc_lane #(.INVERTIBLE(1'b0)) u_rdc_lane_dmi0 (.bit_i(pbit), .invert_i(1'b0),
      .drive_i(dmi_drive),
      .dat_o(dmi_nxt[0]), .oe_o(dmi_oe_nxt[0]));
   rdc_lane #(.INVERTIBLE(1'b0)) u_rdc_lane_dmi1 (.bit_i(pbit), .invert_i(1'b0),
      .drive_i(dmi_drive),
      .dat_o(dmi_nxt[1]), .oe_o(dmi_oe_nxt[1]));

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         bit_r <= 4'h0;
         active_r <= 1'b0;
         dq_r <= '0;
         dq_oe_r <= '0;
         dmi_r <= '0;
         dmi_oe_r <= '0;
         busy_o <= 1'b0;
      end else begin
         bit_r <= bit_nxt;
         active_r <= active_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
         dmi_r <= dmi_nxt;
         dmi_oe_r <= dmi_oe_nxt;
         busy_o <= active_nxt;
      end
   end

   assign link.dq = dq_r;
   assign link.dq_oe = dq_oe_r;
   assign link.dmi = dmi_r;
   assign link.dmi_oe = dmi_oe_r;
endmodule

// one output lane; a lane built without the inverter ignores any mask bit
module rdc_lane #(
   parameter logic INVERTIBLE = 1'b1
) (
   input wire logic bit_i,
   input wire logic invert_i,
   input wire logic drive_i,
   output logic dat_o,
   output logic oe_o
);
   always_comb begin
      dat_o = 1'b0;
      oe_o = 1'b0;
      if (drive_i) begin
         // pattern bit, flipped only by the lane mask bit; bus-inversion coding is never applied here
         dat_o = bit_i ^ (invert_i && INVERTIBLE); // R3 R6 R7
         oe_o = 1'b1;
      end
   end
endmodule

//--- rtl/rdc_ctl.sv
// rdc_ctl: controller end that issues calibration and captures bursts
`timescale 1ns/1ps
module rdc_ctl (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic [5:0] read_latency_o,
   rdc_link_if.ctl link
);
   typedef enum logic [1:0] {
      RDC_ST_IDLE = 2'b00,
      RDC_ST_CAS2 = 2'b01
   } rdc_state_t;
   rdc_state_t st_r, st_nxt;
   rdc_pkg::rdc_cmd_t cmd_r, cmd_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic [7:0] data_r, data_nxt;
   logic [5:0] rl_nxt;
   logic [15:0] cap_lo_r, cap_lo_nxt;
   logic [15:0] cap_hi_r, cap_hi_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] bursts_r, bursts_nxt;
   logic [31:0] rdata_nxt;
   logic [15:0] dq_s1_r, dq_s2_r;
   logic [15:0] oe_s1_r, oe_s2_r;

   always_ff @(posedge ref_clk_i) begin
      dq_s1_r <= link.dq;
      dq_s2_r <= dq_s1_r;
      oe_s1_r <= link.dq_oe;
      oe_s2_r <= oe_s1_r;
   end

   always_comb begin
      st_nxt = st_r;
      cmd_nxt = rdc_pkg::RDC_CMD_NONE;
      sel_nxt = sel_r;
      data_nxt = data_r;
      rl_nxt = read_latency_o;
      cap_lo_nxt = cap_lo_r;
      cap_hi_nxt = cap_hi_r;
      cnt_nxt = cnt_r;
      bursts_nxt = bursts_r;
      rdata_nxt = 32'h0000_0000;
      case (st_r)
         RDC_ST_IDLE: begin
            if (wr_i && addr_i == rdc_pkg::REG_MRW) begin
               cmd_nxt = rdc_pkg::RDC_CMD_MRW;
               sel_nxt = wdata_i[10:8];
               data_nxt = wdata_i[7:0];
            end else if (wr_i && addr_i == rdc_pkg::REG_CTRL && wdata_i[0]) begin
               cmd_nxt = rdc_pkg::RDC_CMD_CAL;
               st_nxt = RDC_ST_CAS2;
            end
         end
         RDC_ST_CAS2: begin
            cmd_nxt = rdc_pkg::RDC_CMD_CAS2; // R11
            st_nxt = RDC_ST_IDLE;
         end
         default: st_nxt = RDC_ST_IDLE;
      endcase
      if (wr_i && addr_i == rdc_pkg::REG_RL) begin
         rl_nxt = wdata_i[5:0];
      end
      // capture: bit order is lsb first, low byte then high byte
      if (oe_s2_r[0]) begin
         cap_lo_nxt = {dq_s2_r[0], cap_lo_r[15:1]};
         cap_hi_nxt = {dq_s2_r[8], cap_hi_r[15:1]};
         cnt_nxt = cnt_r + 4'h1;
         if (cnt_r == 4'hf) begin
            bursts_nxt = bursts_r + 8'h01;
         end
      end
      if (rd_i) begin
         case (addr_i)
            rdc_pkg::REG_STATUS: rdata_nxt = {23'h0, st_r != RDC_ST_IDLE, bursts_r};
            rdc_pkg::REG_RL: rdata_nxt = {26'h0, read_latency_o};
            rdc_pkg::REG_CAP_LO: rdata_nxt = {16'h0, cap_lo_r};
            rdc_pkg::REG_CAP_HI: rdata_nxt = {16'h0, cap_hi_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         st_r <= RDC_ST_IDLE;
         cmd_r <= rdc_pkg::RDC_CMD_NONE;
         sel_r <= 3'h0;
         data_r <= 8'h00;
         read_latency_o <= rdc_pkg::RL_RST;
         cap_lo_r <= 16'h0000;
         cap_hi_r <= 16'h0000;
         cnt_r <= 4'h0;
         bursts_r <= 8'h00;
         rdata_o <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         sel_r <= sel_nxt;
         data_r <= data_nxt;
         read_latency_o <= rl_nxt;
         cap_lo_r <= cap_lo_nxt;
         cap_hi_r <= cap_hi_nxt;
         cnt_r <= cnt_nxt;
         bursts_r <= bursts_nxt;
         rdata_o <= rdata_nxt;
      end
   end

   assign link.cmd = cmd_r;
   assign link.mrw_sel = sel_r;
   assign link.mrw_data = data_r;
   assign link.cas2_op = 6'h00; // R12
endmodule

//--- tb/rdc_link_asserts.sv
// rdc_link_asserts: protocol checks on the calibration link
`timescale 1ns/1ps
module rdc_link_asserts (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire rdc_pkg::rdc_cmd_t cmd,
   input wire logic [5:0] cas2_op,
   input wire logic [15:0] dq,
   input wire logic [15:0] dq_oe,
   input wire logic [1:0] dmi,
   input wire logic [1:0] dmi_oe
);
   // read latency assumed at its reset value of 6; reprogramming it breaks a_burst_start
   logic [3:0] beat_r;
   logic [3:0] beat_nxt;
   logic [15:0] inv_r;
   logic [15:0] inv_nxt;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   always_comb begin
      beat_nxt = dq_oe[0] ? beat_r + 4'h1 : 4'h0;
      inv_nxt = dq ^ {16{dmi[0]}};
   end
   always_ff @(posedge ref_clk_i) begin
      beat_r <= resetn_i ? beat_nxt : 4'h0;
      inv_r <= inv_nxt;
   end
   a_cas2_follows: assert property (cmd == rdc_pkg::RDC_CMD_CAL |=>
      cmd == rdc_pkg::RDC_CMD_CAS2) else $error("cas2 did not follow cal");
   a_cas2_op_low: assert property (cmd == rdc_pkg::RDC_CMD_CAS2 |-> cas2_op == 6'h00)
      else $error("cas2 operands not low");
   a_burst_start: assert property (cmd == rdc_pkg::RDC_CMD_CAS2 &&
      $past(cmd) == rdc_pkg::RDC_CMD_CAL && !dq_oe[0] |-> !dq_oe[0] [*7] ##1 dq_oe[0])
      else $error("burst not launched after read latency");
   a_burst_len: assert property ($fell(dq_oe[0]) |-> beat_r == 4'h0)
      else $error("burst not a multiple of sixteen beats");
   a_all_lanes: assert property (dq_oe == 16'h0000 || dq_oe == 16'hffff)
      else $error("lanes not driven together");
   a_dmi_pair: assert property (dmi_oe == 2'b11 |-> dmi[0] == dmi[1])
      else $error("dmi pins differ");
   a_dmi_in_burst: assert property (dmi_oe != 2'b00 |->
      dq_oe == 16'hffff && dmi_oe == 2'b11) else $error("dmi driven outside burst");
   a_mask_steady: assert property (dq_oe[0] && $past(dq_oe[0]) && dmi_oe[0] |->
      inv_nxt == inv_r) else $error("lane inversion changed in burst");
endmodule

//--- tb/rdc_link_tb_top.sv
// rdc_link_tb_top: register-port regression of the calibration link
`timescale 1ns/1ps
module rdc_link_tb_top;
   logic ref_clk_i;
   logic resetn_i;
   logic [3:0] addr_i;
   logic [31:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [31:0] rdata_o;
   logic [5:0] rl;
   logic busy;
   logic prev_oe;
   int num_errors;
   int total_checks;
   int falls;
   int f0;
   logic [15:0] q_dq[$];
   logic [3:0] q_dmi[$];
   rdc_link_if link ();
   rdc_mem u_rdc_mem (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .read_latency_i(rl),
      .link(link), .busy_o(busy));
   rdc_ctl u_rdc_ctl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .read_latency_o(rl), .link(link));
   rdc_link_asserts u_rdc_link_asserts (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .cmd(link.cmd), .cas2_op(link.cas2_op), .dq(link.dq), .dq_oe(link.dq_oe),
      .dmi(link.dmi), .dmi_oe(link.dmi_oe));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   // wire monitor: the expected pattern is worked out independently of the capture regs
   always @(posedge ref_clk_i) begin
      if (link.dq_oe[0] === 1'b1) begin
         q_dq.push_back(link.dq);
         q_dmi.push_back({link.dmi_oe, link.dmi});
      end
      if (prev_oe === 1'b1 && link.dq_oe[0] === 1'b0) falls++;
      prev_oe = link.dq_oe[0];
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("rdata", exp, rdata_o);
   endtask
   task automatic mrw(input logic [2:0] sel, input logic [7:0] d);
      wr(rdc_pkg::REG_MRW, {21'h0, sel, d});
   endtask
   // requests spaced 16 cycles apart so consecutive bursts join seamlessly
   task automatic cal(input int n);
      int k;
      q_dq.delete();
      q_dmi.delete();
      // no array read and no power-down is ever issued, so both spacings hold
      repeat (n) begin
         wr(rdc_pkg::REG_CTRL, 32'h1);
         repeat (14) @(posedge ref_clk_i);
      end
      for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge ref_clk_i);
      repeat (2) @(posedge ref_clk_i);
      chk("busy", 32'h0, {31'h0, busy});
   endtask
   task automatic expect_burst(input logic [7:0] p1, p2, lm, hm, input logic oe, input int n);
      logic [15:0] pat;
      pat = {p2, p1};
      chk("beats", 32'(16 * n), 32'(q_dq.size()));
      for (int i = 0; i < 16 * n; i++) begin
         chk("dq", {16'h0, {16{pat[i % 16]}} ^ {hm, lm}}, {16'h0, q_dq[i]});
         chk("dmi_oe", {30'h0, oe, oe}, {30'h0, q_dmi[i][3:2]});
         if (oe) chk("dmi", {30'h0, {2{pat[i % 16]}}}, {30'h0, q_dmi[i][1:0]});
      end
   endtask
   task automatic results;
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      resetn_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rd(rdc_pkg::REG_RL, 32'h6);
      rd(rdc_pkg::REG_STATUS, 32'h0);
      rd(4'hf, 32'h0);
      cal(1);
      expect_burst(8'h5a, 8'h3c, 8'h55, 8'h55, 1'b1, 1);
      rd(rdc_pkg::REG_STATUS, 32'h1);
      rd(rdc_pkg::REG_CAP_LO, 32'hc3a5);
      rd(rdc_pkg::REG_CAP_HI, 32'hc3a5);
      mrw(rdc_pkg::SEL_FIRST, 8'h27);
      mrw(rdc_pkg::SEL_SECOND, 8'h59);
      // walks one mask bit per lane byte while sweeping all dm and inversion settings
      for (int c = 0; c < 8; c++) begin
         mrw(rdc_pkg::SEL_LOW_MASK, 8'h01 << c);
         mrw(rdc_pkg::SEL_HIGH_MASK, 8'h80 >> c);
         mrw(rdc_pkg::SEL_CFG, {3'(c), 5'h0});
         cal(1);
         expect_burst(8'h27, 8'h59, 8'h01 << c, 8'h80 >> c, c != 1, 1);
      end
      f0 = falls;
      cal(2);
      expect_burst(8'h27, 8'h59, 8'h80, 8'h01, 1'b1, 2);
      chk("gaps", 32'h1, 32'(falls - f0));
      results();
   end
   initial begin
      #50000;
      num_errors++;
      results();
   end
endmodule
